// >>> core/aux_input_pkg.sv
// Purpose: shared constants for the auxiliary input configuration block
// Assumes: byte-wide registers, 100 MHz clock
// Notes:   times in microseconds, counts derived from the clock period
package aux_input_pkg;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  OFS_OV_THRESH  = 8'h38;
  localparam logic [7:0]  OFS_OV_HYST    = 8'h39;
  localparam logic [7:0]  OFS_UV_THRESH  = 8'h3a;
  localparam logic [7:0]  OFS_UV_HYST    = 8'h3b;
  localparam logic [7:0]  OFS_FAULT_CFG  = 8'h3c;
  localparam logic [7:0]  OFS_FUNC_SEL   = 8'h3d;
  localparam logic [7:0]  OFS_DIGIN_CFG  = 8'h3e;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h31;
  localparam logic [7:0]  OFS_LIVE_STATE = 8'h32;

  // --------------------------------------------------------------------
  // field layout
  // --------------------------------------------------------------------
  localparam int HYST_W       = 5;
  localparam int FCFG_W       = 5;
  localparam int FCFG_GF_LSB  = 2;
  localparam int FCFG_RS_LSB  = 0;
  localparam int SEL_W        = 2;
  localparam int DCFG_W       = 7;
  localparam int DCFG_INV     = 6;
  localparam int DCFG_TYP     = 5;
  localparam int DCFG_PUL_LSB = 3;
  localparam int DCFG_GF_LSB  = 0;
  localparam int IRQ_W        = 3;
  localparam int IRQ_OV       = 0;
  localparam int IRQ_UV       = 1;
  localparam int IRQ_GPI      = 2;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_OV_THRESH = 8'hff;
  localparam logic [7:0] RST_UV_THRESH = 8'h00;
  localparam logic [4:0] RST_HYST      = 5'h00;
  localparam logic [4:0] RST_FAULT_CFG = 5'h03;
  localparam logic [1:0] RST_FUNC_SEL  = 2'h3;
  localparam logic [6:0] RST_DIGIN_CFG = 7'h00;

  // --------------------------------------------------------------------
  // encodings
  // --------------------------------------------------------------------
  localparam logic [1:0] FT_OVER  = 2'h0;
  localparam logic [1:0] FT_EITHER = 2'h1;
  localparam logic [1:0] FT_UNDER = 2'h2;
  localparam logic [1:0] FS_SFD_ONLY  = 2'h0;
  localparam logic [1:0] FS_GPI_ONLY  = 2'h1;
  localparam logic [1:0] FS_GPI_WARN  = 2'h2;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 14;
  localparam int unsigned GLITCH_US [0:7] =
    '{0, 5, 10, 20, 30, 50, 75, 100};
  localparam int unsigned PULSE_US [0:3] = '{10, 100, 1000, 10000};

endpackage : aux_input_pkg

// >>> core/filt_if.sv
// Purpose: carrier between the block and one glitch filter
// Assumes: limit counted in microsecond ticks
// Notes:   one instance per filtered signal
`timescale 1ns/1ps
interface filt_if;
  logic                              tick;
  logic [aux_input_pkg::TICK_W-1:0]  limit;
  logic                              din;
  logic                              dout;
  modport owner (output tick, output limit, output din, input dout);
  modport filt  (input tick, input limit, input din, output dout);
endinterface : filt_if

// >>> core/glitch_filter.sv
// Purpose: reject pulses shorter than a programmable number of ticks
// Assumes: tick is a one-cycle strobe once per microsecond
// Notes:   limit zero passes the input one cycle later
`timescale 1ns/1ps
module glitch_filter (
  input wire logic clk,
  input wire logic rst,
  filt_if.filt     f
);

  logic [aux_input_pkg::TICK_W-1:0] count;

  // output changes only after the input held its new value long enough
  always_ff @(posedge clk) begin
    if (rst) begin
      count  <= '0;
      f.dout <= 1'b0;
    end else if (f.din == f.dout) begin
      count <= '0;
    end else if (count >= f.limit) begin
      f.dout <= f.din;
      count  <= '0;
    end else if (f.tick) begin
      count <= count + 1'b1;
    end
  end

endmodule : glitch_filter

// >>> core/aux_input_fault_gpi_config.sv
// Purpose: register bank and conditioning of one supervised input
// Assumes: sample is a converted level, synchronous to MCLK
// Notes:   outputs registered; interrupt status cleared by writing one
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module aux_input_fault_gpi_config #(
  parameter int          US_CYC                = aux_input_pkg::US_CYCLES,
  parameter int unsigned GLITCH_TICKS [0:7]    = aux_input_pkg::GLITCH_US,
  parameter int unsigned PULSE_TICKS  [0:3]    = aux_input_pkg::PULSE_US
) (
  input  wire logic                             MCLK,
  input  wire logic                             RST,
  input  wire logic [aux_input_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [aux_input_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                             REG_WR,
  input  wire logic                             REG_RD,
  output      logic [aux_input_pkg::DATA_W-1:0] REG_RDATA,
  input  wire logic                             INPUT_LEVEL,
  input  wire logic [7:0]                       INPUT_SAMPLE,
  output      logic                             FAULT,
  output      logic                             WARNING,
  output      logic                             GPI_OUT,
  output      logic                             IRQ
);

  localparam int TW = aux_input_pkg::TICK_W;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0]                       over_threshold_value;
  logic [aux_input_pkg::HYST_W-1:0] over_hyst;
  logic [7:0]                       under_threshold_value;
  logic [aux_input_pkg::HYST_W-1:0] under_hyst;
  logic [aux_input_pkg::FCFG_W-1:0] fault_cfg;
  logic [aux_input_pkg::SEL_W-1:0]  function_select;
  logic [aux_input_pkg::DCFG_W-1:0] digin_cfg;
  logic [aux_input_pkg::IRQ_W-1:0]  irq_status;
  logic [aux_input_pkg::IRQ_W-1:0]  irq_mask;

  // --------------------------------------------------------------------
  // field views
  // --------------------------------------------------------------------
  logic       input_invert;
  logic       detect_type;
  logic [1:0] edge_pulse_length;
  logic [2:0] glitch_filter_time;
  logic [2:0] sfd_glitch_time;
  logic [1:0] fault_type_select;

  assign input_invert       = digin_cfg[aux_input_pkg::DCFG_INV];
  assign detect_type        = digin_cfg[aux_input_pkg::DCFG_TYP];
  assign edge_pulse_length  =
    digin_cfg[aux_input_pkg::DCFG_PUL_LSB +: 2];
  assign glitch_filter_time =
    digin_cfg[aux_input_pkg::DCFG_GF_LSB +: 3];
  assign sfd_glitch_time    =
    fault_cfg[aux_input_pkg::FCFG_GF_LSB +: 3];
  assign fault_type_select  =
    fault_cfg[aux_input_pkg::FCFG_RS_LSB +: 2];

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      over_threshold_value  <= aux_input_pkg::RST_OV_THRESH;
      over_hyst             <= aux_input_pkg::RST_HYST;
      under_threshold_value <= aux_input_pkg::RST_UV_THRESH;
      under_hyst            <= aux_input_pkg::RST_HYST;
      fault_cfg             <= aux_input_pkg::RST_FAULT_CFG;
      function_select       <= aux_input_pkg::RST_FUNC_SEL;
      digin_cfg             <= aux_input_pkg::RST_DIGIN_CFG;
      irq_mask              <= '0;
    end else if (REG_WR) begin
      case (REG_ADDR)
        aux_input_pkg::OFS_OV_THRESH:
          over_threshold_value <= REG_WDATA;
        aux_input_pkg::OFS_OV_HYST:
          over_hyst <= REG_WDATA[aux_input_pkg::HYST_W-1:0];
        aux_input_pkg::OFS_UV_THRESH:
          under_threshold_value <= REG_WDATA;
        aux_input_pkg::OFS_UV_HYST:
          under_hyst <= REG_WDATA[aux_input_pkg::HYST_W-1:0];
        aux_input_pkg::OFS_FAULT_CFG:
          fault_cfg <= REG_WDATA[aux_input_pkg::FCFG_W-1:0];
        aux_input_pkg::OFS_FUNC_SEL:
          function_select <= REG_WDATA[aux_input_pkg::SEL_W-1:0];
        aux_input_pkg::OFS_DIGIN_CFG:
          digin_cfg <= REG_WDATA[aux_input_pkg::DCFG_W-1:0];
        aux_input_pkg::OFS_IRQ_MASK:
          irq_mask <= REG_WDATA[aux_input_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // microsecond timebase
  // --------------------------------------------------------------------
  logic [15:0] tick_count;
  logic        tick;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      tick_count <= '0;
      tick       <= 1'b0;
    end else if (tick_count >= 16'(US_CYC - 1)) begin
      tick_count <= '0;
      tick       <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick       <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // supply fault detector
  // --------------------------------------------------------------------
  logic       over_raw;
  logic       under_raw;
  logic [8:0] over_release;
  logic [8:0] under_release;
  logic       over_release_ok;

  assign over_release    = {1'b0, over_threshold_value}
                         - {4'h0, over_hyst};
  assign under_release   = {1'b0, under_threshold_value}
                         + {4'h0, under_hyst};
  assign over_release_ok = over_threshold_value >= {3'h0, over_hyst};

  // set beyond threshold, clear only past the hysteresis band
  always_ff @(posedge MCLK) begin
    if (RST) begin
      over_raw <= 1'b0;
    end else if (INPUT_SAMPLE > over_threshold_value) begin
      over_raw <= 1'b1;
    end else if (over_release_ok &&
                 {1'b0, INPUT_SAMPLE} < over_release) begin
      over_raw <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      under_raw <= 1'b0;
    end else if (INPUT_SAMPLE < under_threshold_value) begin
      under_raw <= 1'b1;
    end else if ({1'b0, INPUT_SAMPLE} > under_release) begin
      under_raw <= 1'b0;
    end
  end

  filt_if over_f ();
  filt_if under_f ();

  assign over_f.tick   = tick;
  assign over_f.din    = over_raw;
  assign over_f.limit  = TW'(GLITCH_TICKS[sfd_glitch_time]);
  assign under_f.tick  = tick;
  assign under_f.din   = under_raw;
  assign under_f.limit = TW'(GLITCH_TICKS[sfd_glitch_time]);

  glitch_filter u_over_filter (
    .clk (MCLK),
    .rst (RST),
    .f   (over_f.filt)
  );

  glitch_filter u_under_filter (
    .clk (MCLK),
    .rst (RST),
    .f   (under_f.filt)
  );

  logic sfd_fault;

  always_comb begin
    case (fault_type_select)
      aux_input_pkg::FT_OVER:   sfd_fault = over_f.dout;
      aux_input_pkg::FT_EITHER: sfd_fault = over_f.dout | under_f.dout;
      aux_input_pkg::FT_UNDER:  sfd_fault = under_f.dout;
      default:                  sfd_fault = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // general digital input
  // --------------------------------------------------------------------
  filt_if gpi_f ();

  assign gpi_f.tick  = tick;
  assign gpi_f.din   = INPUT_LEVEL ^ input_invert;
  assign gpi_f.limit = TW'(GLITCH_TICKS[glitch_filter_time]);

  glitch_filter u_gpi_filter (
    .clk (MCLK),
    .rst (RST),
    .f   (gpi_f.filt)
  );

  logic          gpi_prev;
  logic          gpi_edge;
  logic          pulse_active;
  logic [TW-1:0] pulse_count;
  logic [TW-1:0] pulse_len;

  assign gpi_edge  = gpi_f.dout & ~gpi_prev;
  assign pulse_len = TW'(PULSE_TICKS[edge_pulse_length]);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      gpi_prev <= 1'b0;
    end else begin
      gpi_prev <= gpi_f.dout;
    end
  end

  // edge restarts the pulse; it ends on the tick after the count reaches the selected length
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pulse_active <= 1'b0;
      pulse_count  <= '0;
    end else if (gpi_edge) begin
      pulse_active <= 1'b1;
      pulse_count  <= '0;
    end else if (pulse_active && tick) begin
      if (pulse_count >= pulse_len) begin
        pulse_active <= 1'b0;
      end else begin
        pulse_count <= pulse_count + 1'b1;
      end
    end
  end

  logic gpi_result;

  assign gpi_result = detect_type ? pulse_active : gpi_f.dout;

  // --------------------------------------------------------------------
  // function routing and outputs
  // --------------------------------------------------------------------
  logic next_fault;
  logic next_warning;

  always_comb begin
    next_fault   = 1'b0;
    next_warning = 1'b0;
    case (function_select)
      aux_input_pkg::FS_SFD_ONLY: next_fault = sfd_fault;
      aux_input_pkg::FS_GPI_ONLY: next_fault = gpi_result;
      aux_input_pkg::FS_GPI_WARN: begin
        next_fault   = gpi_result;
        next_warning = sfd_fault;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      FAULT   <= 1'b0;
      WARNING <= 1'b0;
      GPI_OUT <= 1'b0;
    end else begin
      FAULT   <= next_fault;
      WARNING <= next_warning;
      GPI_OUT <= gpi_result;
    end
  end

  // --------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------
  logic                            over_prev;
  logic                            under_prev;
  logic [aux_input_pkg::IRQ_W-1:0] irq_event;
  logic [aux_input_pkg::IRQ_W-1:0] irq_clear;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      over_prev  <= 1'b0;
      under_prev <= 1'b0;
    end else begin
      over_prev  <= over_f.dout;
      under_prev <= under_f.dout;
    end
  end

  always_comb begin
    irq_event                         = '0;
    irq_event[aux_input_pkg::IRQ_OV]  = over_f.dout & ~over_prev;
    irq_event[aux_input_pkg::IRQ_UV]  = under_f.dout & ~under_prev;
    irq_event[aux_input_pkg::IRQ_GPI] = gpi_edge;
  end

  assign irq_clear = (REG_WR && REG_ADDR == aux_input_pkg::OFS_IRQ_STATUS)
                   ? REG_WDATA[aux_input_pkg::IRQ_W-1:0] : '0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // --------------------------------------------------------------------
  // register reads
  // --------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    case (REG_ADDR)
      aux_input_pkg::OFS_OV_THRESH:  next_rdata = over_threshold_value;
      aux_input_pkg::OFS_OV_HYST:    next_rdata = {3'h0, over_hyst};
      aux_input_pkg::OFS_UV_THRESH:  next_rdata = under_threshold_value;
      aux_input_pkg::OFS_UV_HYST:    next_rdata = {3'h0, under_hyst};
      aux_input_pkg::OFS_FAULT_CFG:  next_rdata = {3'h0, fault_cfg};
      aux_input_pkg::OFS_FUNC_SEL:   next_rdata = {6'h00, function_select};
      aux_input_pkg::OFS_DIGIN_CFG:  next_rdata = {1'b0, digin_cfg};
      aux_input_pkg::OFS_IRQ_STATUS: next_rdata = {5'h00, irq_status};
      aux_input_pkg::OFS_IRQ_MASK:   next_rdata = {5'h00, irq_mask};
      aux_input_pkg::OFS_LIVE_STATE:
        next_rdata = {2'h0, pulse_active, gpi_f.dout, sfd_fault,
                      gpi_result, under_f.dout, over_f.dout};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= '0;
    end
  end

endmodule : aux_input_fault_gpi_config

// >>> verif/aux_input_props.sv
// Purpose: port checks for the auxiliary input block
// Assumes: configuration shadowed from register writes
// Notes:   checks wait until configuration has been quiet a while
`timescale 1ns/1ps
module aux_input_props #(
  parameter int          US_CYC             = aux_input_pkg::US_CYCLES,
  parameter int unsigned GLITCH_TICKS [0:7] = aux_input_pkg::GLITCH_US,
  parameter int unsigned PULSE_TICKS  [0:3] = aux_input_pkg::PULSE_US
) (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       INPUT_LEVEL,
  input wire logic [7:0] INPUT_SAMPLE,
  input wire logic       FAULT,
  input wire logic       WARNING,
  input wire logic       GPI_OUT,
  input wire logic       IRQ
);
  // ------------------------------------------------------------------
  // shadow configuration
  // ------------------------------------------------------------------
  logic [6:0] dcfg;
  logic [1:0] fsel;
  logic [4:0] fcfg;
  logic [7:0] ovth;
  logic [3:0] quiet;
  logic [7:0] stab;
  logic [7:0] hi_cnt;
  logic       lin;
  logic       ok;
  assign lin = INPUT_LEVEL ^ dcfg[6];
  assign ok  = quiet[3];

  always_ff @(posedge MCLK) begin
    if (RST) begin
      dcfg <= aux_input_pkg::RST_DIGIN_CFG;
      fsel <= aux_input_pkg::RST_FUNC_SEL;
      fcfg <= aux_input_pkg::RST_FAULT_CFG;
      ovth <= aux_input_pkg::RST_OV_THRESH;
    end else if (REG_WR) begin
      if (REG_ADDR == aux_input_pkg::OFS_DIGIN_CFG) dcfg <= REG_WDATA[6:0];
      if (REG_ADDR == aux_input_pkg::OFS_FUNC_SEL) fsel <= REG_WDATA[1:0];
      if (REG_ADDR == aux_input_pkg::OFS_FAULT_CFG) fcfg <= REG_WDATA[4:0];
      if (REG_ADDR == aux_input_pkg::OFS_OV_THRESH) ovth <= REG_WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST || REG_WR) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end

  always_ff @(posedge MCLK) begin
    if (RST || $changed(INPUT_LEVEL)) stab <= 8'h00;
    else if (stab != 8'hff) stab <= stab + 8'h01;
  end

  always_ff @(posedge MCLK) begin
    if (RST || !GPI_OUT) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence in_rose2;
    $past(lin, 2) && !$past(lin, 3);
  endsequence
  sequence in_rose3;
    $past(lin, 3) && !$past(lin, 4);
  endsequence

  level_follow_a : assert property (
    ok && !dcfg[5] && dcfg[2:0] == 3'h0 |->
    GPI_OUT == ($past(INPUT_LEVEL, 2) ^ dcfg[6]))
    else $error("level output does not follow input");
  edge_start_a : assert property (
    $rose(GPI_OUT) && ok && dcfg[5] && dcfg[2:0] == 3'h0 |->
    in_rose2 or in_rose3)
    else $error("pulse without rising input");
  pulse_len_a : assert property (
    $fell(GPI_OUT) && ok && dcfg[5] |->
    $past(hi_cnt) + 2 >= PULSE_TICKS[dcfg[4:3]] * US_CYC)
    else $error("edge pulse too short");
  glitch_hold_a : assert property (
    $changed(GPI_OUT) && ok && !dcfg[5] |->
    $past(stab, 2) + US_CYC + 3 >= GLITCH_TICKS[dcfg[2:0]] * US_CYC)
    else $error("short input pulse passed filter");
  over_set_a : assert property (
    $rose(FAULT) && ok && fsel == 2'h0 && fcfg == 5'h00 |->
    $past(INPUT_SAMPLE, 2) > ovth || $past(INPUT_SAMPLE, 3) > ovth ||
    $past(INPUT_SAMPLE, 4) > ovth)
    else $error("fault raised without sample above threshold");
endmodule : aux_input_props

bind aux_input_fault_gpi_config aux_input_props #(
  .US_CYC(US_CYC), .GLITCH_TICKS(GLITCH_TICKS), .PULSE_TICKS(PULSE_TICKS)
) u_aux_input_props (
  .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .INPUT_LEVEL(INPUT_LEVEL), .INPUT_SAMPLE(INPUT_SAMPLE), .FAULT(FAULT),
  .WARNING(WARNING), .GPI_OUT(GPI_OUT), .IRQ(IRQ)
);

// >>> verif/testbench.sv
// Purpose: self-checking bench for the auxiliary input block
// Assumes: short tick, filter and pulse tables for quick runs
// Notes:   random stimulus from a fixed seed
`timescale 1ns/1ps
module testbench;
  localparam int          US       = 2;
  localparam int unsigned GT [0:7] = '{0, 1, 2, 3, 4, 5, 6, 7};
  localparam int unsigned PT [0:3] = '{2, 3, 4, 5};
  logic       MCLK         = 1'b0;
  logic       RST          = 1'b1;
  logic [7:0] REG_ADDR     = 8'h00;
  logic [7:0] REG_WDATA    = 8'h00;
  logic       REG_WR       = 1'b0;
  logic       REG_RD       = 1'b0;
  logic       INPUT_LEVEL  = 1'b0;
  logic [7:0] INPUT_SAMPLE = 8'h78;
  logic [7:0] REG_RDATA;
  logic       FAULT;
  logic       WARNING;
  logic       GPI_OUT;
  logic       IRQ;
  int         err_total    = 0;
  int         n_tests      = 0;
  int         seed         = 35565;
  int         len;
  int         ho;
  int         hu;
  logic [7:0] rv;
  logic [7:0] wv;
  logic [1:0] h;
  logic [1:0] fs;
  logic       seen;
  logic       ovf          = 1'b0;
  logic       uvf          = 1'b0;
  logic       supply_fault_detector;
  logic [7:0] rst_tab [0:6] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h03,
                                8'h03, 8'h00};
  logic [7:0] msk_tab [0:6] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h1f,
                                8'h03, 8'h7f};

  always #5 MCLK = ~MCLK;

  aux_input_fault_gpi_config #(
    .US_CYC(US), .GLITCH_TICKS(GT), .PULSE_TICKS(PT)
  ) u_aux_input_fault_gpi_config (
    .MCLK(MCLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .INPUT_LEVEL(INPUT_LEVEL), .INPUT_SAMPLE(INPUT_SAMPLE), .FAULT(FAULT),
    .WARNING(WARNING), .GPI_OUT(GPI_OUT), .IRQ(IRQ)
  );

  // ------------------------------------------------------------------
  // expectation helpers and bus tasks
  // ------------------------------------------------------------------
  function automatic logic ov_next(logic f, int s, int th, int hy);
    return f ? (s + hy >= th) : (s > th);
  endfunction : ov_next
  function automatic logic uv_next(logic f, int s, int th, int hy);
    return f ? (s <= th + hy) : (s < th);
  endfunction : uv_next
  function automatic logic in_rng(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction : in_rng

  task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD   <= 1'b0;
    #1 d = REG_RDATA;
  endtask : rd
  task automatic samp(input logic [7:0] v);
    @(posedge MCLK);
    INPUT_SAMPLE <= v;
    tick(8);
    #1;
  endtask : samp

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  initial begin
    tick(6);
    RST <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(8'h38 + i[7:0], rv);
      check(rv, rst_tab[i]);
      wv = 8'($random(seed));
      wr(8'h38 + i[7:0], wv);
      rd(8'h38 + i[7:0], rv);
      check(rv, wv & msk_tab[i]);
    end
    rd(8'h3f, rv);
    check(rv, 8'h00);
    wr(aux_input_pkg::OFS_FUNC_SEL, 8'h01);
    for (int inv = 0; inv < 2; inv++) begin
      wr(aux_input_pkg::OFS_DIGIN_CFG, 8'(inv << 6));
      h = 2'b00;
      for (int k = 0; k < 40; k++) begin
        @(posedge MCLK);
        INPUT_LEVEL <= 1'($random(seed));
        #1;
        if (k > 2) check(GPI_OUT, h[1] ^ inv[0]);
        if (k > 2) check(FAULT, h[1] ^ inv[0]);
        h = {h[0], INPUT_LEVEL};
      end
    end
    for (int g = 1; g < 8; g++) begin
      @(posedge MCLK);
      INPUT_LEVEL <= 1'b0;
      wr(aux_input_pkg::OFS_DIGIN_CFG, 8'(g));
      tick(2 * g + 6);
      if (g > 1) begin
        INPUT_LEVEL <= 1'b1;
        tick(2 * g - 2);
        INPUT_LEVEL <= 1'b0;
        seen = 1'b0;
        repeat (2 * g + 6) begin
          @(posedge MCLK);
          #1 seen = seen | GPI_OUT;
        end
        check(seen, 1'b0);
        @(posedge MCLK);
      end
      INPUT_LEVEL <= 1'b1;
      tick(2 * g + 4);
      #1 check(GPI_OUT, 1'b1);
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge MCLK);
      INPUT_LEVEL <= p[0];
      wr(aux_input_pkg::OFS_DIGIN_CFG, 8'((p[0] << 6) | 32 | (p << 3)));
      tick(16);
      INPUT_LEVEL <= !p[0];
      len = 0;
      repeat (40) begin
        @(posedge MCLK);
        #1 len = len + GPI_OUT;
      end
      check(in_rng(len, PT[p] * US, (PT[p] + 1) * US + 2), 1'b1);
      @(posedge MCLK);
      INPUT_LEVEL <= p[0];
      len = 0;
      repeat (20) begin
        @(posedge MCLK);
        #1 len = len + GPI_OUT;
      end
      check(len, 0);
    end
    @(posedge MCLK);
    INPUT_LEVEL <= 1'b0;
    wr(aux_input_pkg::OFS_DIGIN_CFG, 8'h00);
    ho = $random(seed) & 7;
    hu = $random(seed) & 7;
    wr(aux_input_pkg::OFS_OV_HYST, 8'(ho));
    wr(aux_input_pkg::OFS_UV_HYST, 8'(hu));
    wr(aux_input_pkg::OFS_OV_THRESH, 8'h80);
    wr(aux_input_pkg::OFS_UV_THRESH, 8'h70);
    for (int st = 0; st < 48; st++) begin
      fs = (st % 3 == 0) ? 2'h0 : (st % 3 == 1) ? 2'h2 : 2'h3;
      wr(aux_input_pkg::OFS_FAULT_CFG, 8'(st / 12));
      wr(aux_input_pkg::OFS_FUNC_SEL, 8'(fs));
      samp(8'h68 + 8'($random(seed) & 31));
      ovf = ov_next(ovf, INPUT_SAMPLE, 128, ho);
      uvf = uv_next(uvf, INPUT_SAMPLE, 112, hu);
      supply_fault_detector = (st / 12 == 0) ? ovf : (st / 12 == 1) ? (ovf | uvf) :
            (st / 12 == 2) ? uvf : 1'b0;
      check(FAULT, fs == 2'h0 && supply_fault_detector);
      check(WARNING, fs == 2'h2 && supply_fault_detector);
    end
    wr(aux_input_pkg::OFS_FAULT_CFG, 8'h00);
    wr(aux_input_pkg::OFS_FUNC_SEL, 8'h00);
    samp(8'h60);
    wr(aux_input_pkg::OFS_IRQ_STATUS, 8'h07);
    wr(aux_input_pkg::OFS_IRQ_MASK, 8'h01);
    tick(8);
    #1 check(IRQ, 1'b0);
    samp(8'h90);
    check(IRQ, 1'b1);
    rd(aux_input_pkg::OFS_IRQ_STATUS, rv);
    check(rv & 8'h01, 8'h01);
    wr(aux_input_pkg::OFS_IRQ_STATUS, 8'h01);
    samp(8'h90);
    check(IRQ, 1'b0);
    wr(aux_input_pkg::OFS_IRQ_MASK, 8'h00);
    samp(8'h60);
    samp(8'h90);
    check(IRQ, 1'b0);
    wr(aux_input_pkg::OFS_IRQ_MASK, 8'h01);
    tick(3);
    #1 check(IRQ, 1'b1);
    wr(aux_input_pkg::OFS_IRQ_STATUS, 8'h07);
    tick(3);
    #1 check(IRQ, 1'b0);
    rd(aux_input_pkg::OFS_LIVE_STATE, rv);
    check(rv, 8'h09);
    @(posedge MCLK);
    #1 check(REG_RDATA, 8'h00);
    wr(aux_input_pkg::OFS_FAULT_CFG, 8'h04);
    @(posedge MCLK);
    INPUT_SAMPLE <= 8'h60;
    @(posedge MCLK);
    INPUT_SAMPLE <= 8'h90;
    samp(8'h90);
    check(FAULT, 1'b1);
    samp(8'h60);
    check(FAULT, 1'b0);
    rd(aux_input_pkg::OFS_IRQ_STATUS, rv);
    check(rv, 8'h02);
    complete_run();
  end
endmodule : testbench
